// ---- core/dd_i2c_slave.sv ----
// Behaviour
// [R1] idle bus: clock and data rest high
// [R2] start: data falls while clock high
// [R3] stop: data rises while clock high
// [R4] data stable while clock high; sampled then
// [R5] eight bits then one acknowledge clock
// [R6] unlimited bytes between start and stop
// [R7] ack holds data low over clock high
// [R8] slave receiver only; acknowledge sole output
// [R9] answer only addresses 0111 000, 0111 001
// [R10] address bit 1 compared against strap
// [R11] write only; read address ignored
// [R12] matched level acks; mismatch ignores transfer
// [R13] mismatched device ignores all later bytes
// [R14] control byte: more flag, target select
// [R15] control and command bytes always acknowledged
// [R16] display byte stored at pointer location
// [R17] display ack only when subaddress matches
// [R18] master ends with stop or restart
// [R19] master starts only on idle bus
// [R20] unconnected ack needs master ignoring ack
// [R21] mismatch blocks store, pointer still advances
// [R22] pointer step eight, four, three, two
// [R23] inputs synchronised and deglitched first
// [R24] start or stop resets byte parsing
`include "dd_regs.svh"

module dd_i2c_slave #(
   parameter int LINK_PERIOD_NS = `DD_LINK_PERIOD_NS
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_ack_out_pin,
   output logic o_ack_out_pin,
   output logic o_ack_out_pin_oe,
   input wire logic i_addr_bit_strap,
   input wire logic i_subaddr_pin_lo,
   input wire logic i_subaddr_pin_hi,
   input wire dd_pkg::dd_mode_t i_drive_mode,
   input wire logic i_ptr_load,
   input wire logic [7:0] i_ptr_value,
   input wire logic i_sub_load,
   input wire logic [1:0] i_sub_value,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_byte,
   output logic o_ram_we,
   output logic [7:0] o_ram_addr,
   output logic [7:0] o_ram_data,
   output logic o_busy
);
   // ****************************************
   // link domain: reset release and input conditioning
   // ****************************************
   localparam int SPIKE_CYC = (`DD_SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;

   logic link_rst_a_r;
   logic link_rst_n_r;
   dd_pkg::dd_bus_t bus_f;
   dd_pkg::dd_bus_t bus_q_r;
   logic [4:0] straps_l;
   logic strap_l;
   logic [1:0] pins_l;
   logic [1:0] sub_gray_l;
   logic [1:0] sub_bin_l;
   logic [1:0] sub_gray_s;
   logic [1:0] pins_s;

   // reset asserts at once but leaves in step with the link clock
   always_ff @(posedge i_link_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         link_rst_a_r <= 1'b0;
         link_rst_n_r <= 1'b0;
      end
      else
      begin
         link_rst_a_r <= 1'b1;
         link_rst_n_r <= link_rst_a_r;
      end
   end

   // [R23] bus lines filtered
   // [R1] filter resets to idle high
   dd_sync #(
      .WIDTH(2),
      .FILT(SPIKE_CYC),
      .RST_VAL(`DD_BUS_IDLE)
   ) u_bus_sync (
      .i_clk(i_link_clk),
      .i_rst_n(link_rst_n_r),
      .i_async({i_scl, i_sda}),
      .o_sync(bus_f)
   );

   // straps and the gray subaddress counter pass through three flops, with no spike filter
   dd_sync #(
      .WIDTH(5),
      .FILT(1),
      .RST_VAL(5'h00)
   ) u_strap_sync (
      .i_clk(i_link_clk),
      .i_rst_n(link_rst_n_r),
      .i_async({i_addr_bit_strap, i_subaddr_pin_hi, i_subaddr_pin_lo, sub_gray_s}),
      .o_sync(straps_l)
   );

   assign strap_l = straps_l[4];
   assign pins_l = straps_l[3:2];
   assign sub_gray_l = straps_l[1:0];
   assign sub_bin_l = {sub_gray_l[1], sub_gray_l[1] ^ sub_gray_l[0]};

   // ****************************************
   // link domain: bus events
   // ****************************************
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         bus_q_r <= `DD_BUS_IDLE;
      else
         bus_q_r <= bus_f;
   end

   assign scl_rise = bus_f.scl && !bus_q_r.scl;
   assign scl_fall = !bus_f.scl && bus_q_r.scl;
   // [R2] start detect
   assign start_det = bus_f.scl && bus_q_r.scl && bus_q_r.sda && !bus_f.sda;
   // [R3] stop detect
   assign stop_det = bus_f.scl && bus_q_r.scl && !bus_q_r.sda && bus_f.sda;

   // ****************************************
   // link domain: bit counter and shifter
   // ****************************************
   logic [3:0] cnt_r;
   logic [7:0] shift_r;
   logic [7:0] byte_in;
   logic byte_done;

   // [R24] start or stop restarts count
   // [R5] eight data bits then ack clock
   // [R6] counter wraps, no byte limit
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         cnt_r <= `DD_BIT_FIRST;
      else if (start_det || stop_det)
         cnt_r <= `DD_BIT_FIRST;
      else if (scl_rise)
         cnt_r <= (cnt_r == `DD_BIT_ACK) ? `DD_BIT_FIRST : cnt_r + 4'h1;
   end

   // [R4] sample on clock rise
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         shift_r <= 8'h00;
      else if (scl_rise && (cnt_r != `DD_BIT_ACK))
         shift_r <= {shift_r[6:0], bus_f.sda};
   end

   assign byte_in = {shift_r[6:0], bus_f.sda};
   assign byte_done = scl_rise && (cnt_r == `DD_BIT_LAST) && !start_det && !stop_det;

   // ****************************************
   // link domain: byte parsing
   // ****************************************
   dd_pkg::dd_state_t state_r;
   logic more_r;
   logic sel_r;
   logic addr_hit;
   logic sub_hit;

   // [R9] fixed prefix
   // [R10] bit 1 against strap
   // [R11] read bit must be zero
   assign addr_hit = (byte_in[`DD_ADDR_PREFIX_MSB:`DD_ADDR_PREFIX_LSB] == `DD_ADDR_PREFIX)
      && (byte_in[`DD_ADDR_STRAP_BIT] == strap_l) && !byte_in[`DD_ADDR_RW_BIT];
   assign sub_hit = (sub_bin_l == pins_l);

   // [R12] mismatch skips to next start
   // [R18] restart re-enters address phase
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         state_r <= dd_pkg::DD_IDLE;
      else if (start_det)
         state_r <= dd_pkg::DD_ADDR;
      else if (stop_det)
         state_r <= dd_pkg::DD_IDLE;
      else if (byte_done)
      begin
         case (state_r)
            dd_pkg::DD_ADDR: state_r <= addr_hit ? dd_pkg::DD_CTRL : dd_pkg::DD_SKIP;
            dd_pkg::DD_CTRL: state_r <= dd_pkg::DD_PAY;
            dd_pkg::DD_PAY: state_r <= more_r ? dd_pkg::DD_CTRL : dd_pkg::DD_PAY;
            default: state_r <= state_r;
         endcase
      end
   end

   // [R14] latch more and select flags
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
      begin
         more_r <= 1'b0;
         sel_r <= 1'b0;
      end
      else if (start_det || stop_det)
      begin
         more_r <= 1'b0;
         sel_r <= 1'b0;
      end
      else if (byte_done && (state_r == dd_pkg::DD_CTRL))
      begin
         more_r <= byte_in[`DD_CTRL_MORE_BIT];
         sel_r <= byte_in[`DD_CTRL_SEL_BIT];
      end
   end

   // ****************************************
   // link domain: acknowledge
   // ****************************************
   logic ack_want_r;
   logic ack_nxt;
   logic oe_r;

   always_comb
   begin
      case (state_r)
         dd_pkg::DD_ADDR: ack_nxt = addr_hit;
         // [R15] control byte always acked
         dd_pkg::DD_CTRL: ack_nxt = 1'b1;
         // [R17] display ack needs subaddress match
         dd_pkg::DD_PAY: ack_nxt = sel_r ? sub_hit : 1'b1;
         // [R13] skipped transfer never acked
         default: ack_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         ack_want_r <= 1'b0;
      else if (start_det || stop_det)
         ack_want_r <= 1'b0;
      else if (byte_done)
         ack_want_r <= ack_nxt;
   end

   // [R7] pull low from fall before ack clock to fall after
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         oe_r <= 1'b0;
      else if (start_det || stop_det)
         oe_r <= 1'b0;
      else if (scl_fall && (cnt_r == `DD_BIT_ACK))
         oe_r <= ack_want_r;
      else if (scl_fall)
         oe_r <= 1'b0;
   end

   // [R8] the only bus drive is the ack pull-down
   assign o_ack_out_pin = 1'b0;
   assign o_ack_out_pin_oe = oe_r;

   // ****************************************
   // link domain: payload hand-off
   // ****************************************
   dd_pkg::dd_byte_t pay_r;
   logic tog_r;
   logic busy_l_r;

   // byte is held until the next one, at least nine bus clocks later, far past the crossing
   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
      begin
         pay_r <= '0;
         tog_r <= 1'b0;
      end
      else if (byte_done && (state_r == dd_pkg::DD_PAY))
      begin
         pay_r <= {sel_r, byte_in};
         tog_r <= !tog_r;
      end
   end

   always_ff @(posedge i_link_clk or negedge link_rst_n_r)
   begin
      if (!link_rst_n_r)
         busy_l_r <= 1'b0;
      else
         busy_l_r <= (state_r == dd_pkg::DD_CTRL) || (state_r == dd_pkg::DD_PAY);
   end

   // ****************************************
   // system domain: crossing and outputs
   // ****************************************
   logic [2:0] tog_s_r;
   logic [1:0] busy_s_r;
   logic pay_ev;

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tog_s_r <= 3'h0;
         busy_s_r <= 2'h0;
      end
      else
      begin
         tog_s_r <= {tog_s_r[1:0], tog_r};
         busy_s_r <= {busy_s_r[0], busy_l_r};
      end
   end

   assign pay_ev = tog_s_r[2] ^ tog_s_r[1];
   assign o_busy = busy_s_r[1];

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_cmd_valid <= 1'b0;
         o_cmd_byte <= 8'h00;
      end
      else
      begin
         o_cmd_valid <= pay_ev && !pay_r.is_display;
         o_cmd_byte <= pay_r.data;
      end
   end

   dd_sync #(
      .WIDTH(2),
      .FILT(1),
      .RST_VAL(2'h0)
   ) u_pin_sync (
      .i_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_subaddr_pin_hi, i_subaddr_pin_lo}),
      .o_sync(pins_s)
   );

   // [R16] display byte to pointer logic
   dd_ptr u_ptr (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_disp_valid(pay_ev && pay_r.is_display),
      .i_disp_data(pay_r.data),
      .i_mode(i_drive_mode),
      .i_ptr_load(i_ptr_load),
      .i_ptr_value(i_ptr_value),
      .i_sub_load(i_sub_load),
      .i_sub_value(i_sub_value),
      .i_sub_pins(pins_s),
      .o_ram_we(o_ram_we),
      .o_ram_addr(o_ram_addr),
      .o_ram_data(o_ram_data),
      .o_sub_gray(sub_gray_s)
   );

   // ****************************************
   // checks
   // ****************************************
   sequence s_start;
      start_det;
   endsequence

   sequence s_addr_miss;
      byte_done && (state_r == dd_pkg::DD_ADDR) && (byte_in[`DD_ADDR_STRAP_BIT] != strap_l);
   endsequence

   sequence s_read_addr;
      byte_done && (state_r == dd_pkg::DD_ADDR) && byte_in[`DD_ADDR_RW_BIT];
   endsequence

   start_parse_reset_a: assert property ( // [R24]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      s_start |=> (cnt_r == `DD_BIT_FIRST) && (state_r == dd_pkg::DD_ADDR) && !oe_r)
      else $error("start did not restart byte parsing");

   stop_idle_a: assert property ( // [R3]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      stop_det |=> (state_r == dd_pkg::DD_IDLE) && !ack_want_r)
      else $error("stop did not return to idle");

   ack_hold_a: assert property ( // [R7]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      oe_r && bus_f.scl && !start_det && !stop_det |=> oe_r)
      else $error("acknowledge released while clock high");

   ack_slot_a: assert property ( // [R5]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      oe_r |-> (cnt_r == `DD_BIT_ACK) || (cnt_r == `DD_BIT_FIRST))
      else $error("bus driven outside the acknowledge slot");

   strap_miss_a: assert property ( // [R10]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      s_addr_miss |=> (state_r == dd_pkg::DD_SKIP) && !ack_want_r)
      else $error("address with wrong strap bit accepted");

   read_reject_a: assert property ( // [R11]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      s_read_addr |=> !ack_want_r ##1 !oe_r)
      else $error("read address acknowledged");

   skip_silent_a: assert property ( // [R13]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      (state_r == dd_pkg::DD_SKIP) |-> !oe_r && $stable(tog_r))
      else $error("skipped transfer drove ack or passed data");

   ctrl_ack_a: assert property ( // [R15]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      byte_done && (state_r == dd_pkg::DD_CTRL) |=> ack_want_r)
      else $error("control byte not acknowledged");

   disp_ack_a: assert property ( // [R17]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      byte_done && (state_r == dd_pkg::DD_PAY) && sel_r && !sub_hit |=> !ack_want_r)
      else $error("display byte acked with subaddress mismatch");

   ctrl_route_a: assert property ( // [R14]
      @(posedge i_link_clk) disable iff (!link_rst_n_r)
      byte_done && (state_r == dd_pkg::DD_CTRL)
      |=> (more_r == $past(byte_in[`DD_CTRL_MORE_BIT]))
      && (sel_r == $past(byte_in[`DD_CTRL_SEL_BIT]))
      ##0 (state_r == dd_pkg::DD_PAY))
      else $error("control byte flags not taken");

   cmd_out_a: assert property ( // [R15]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      pay_ev && !pay_r.is_display |=> o_cmd_valid ##1 !o_cmd_valid)
      else $error("command byte not passed as one pulse");
endmodule // dd_i2c_slave

// ---- core/dd_ptr.sv ----
`include "dd_regs.svh"

module dd_ptr (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_disp_valid,
   input wire logic [7:0] i_disp_data,
   input wire dd_pkg::dd_mode_t i_mode,
   input wire logic i_ptr_load,
   input wire logic [7:0] i_ptr_value,
   input wire logic i_sub_load,
   input wire logic [1:0] i_sub_value,
   input wire logic [1:0] i_sub_pins,
   output logic o_ram_we,
   output logic [7:0] o_ram_addr,
   output logic [7:0] o_ram_data,
   output logic [1:0] o_sub_gray
);
   logic [7:0] ptr_r;
   logic [1:0] sub_r;
   logic [1:0] sub_nxt;
   logic [7:0] step;
   logic [8:0] sum;
   logic wrap;
   logic [7:0] ptr_nxt;

   // [R22] step per drive mode
   always_comb
   begin
      case (i_mode)
         dd_pkg::DD_STATIC: step = `DD_STEP_STATIC;
         dd_pkg::DD_MUX2: step = `DD_STEP_MUX2;
         dd_pkg::DD_MUX3: step = `DD_STEP_MUX3;
         default: step = `DD_STEP_MUX4;
      endcase
   end

   assign sum = {1'b0, ptr_r} + {1'b0, step};
   assign wrap = (sum >= {1'b0, `DD_RAM_DEPTH});
   // overflow carries the remainder so a character may straddle two devices
   assign ptr_nxt = wrap ? 8'(sum - {1'b0, `DD_RAM_DEPTH}) : sum[7:0];
   assign sub_nxt = wrap ? sub_r + 2'h1 : sub_r;

   // [R21] pointer advances even when storage blocked
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ptr_r <= `DD_PTR_RST;
         sub_r <= `DD_SUB_RST;
         o_sub_gray <= `DD_SUB_RST;
      end
      else
      begin
         if (i_ptr_load)
            ptr_r <= i_ptr_value;
         else if (i_disp_valid)
            ptr_r <= ptr_nxt;
         if (i_sub_load)
         begin
            sub_r <= i_sub_value;
            o_sub_gray <= i_sub_value ^ (i_sub_value >> 1);
         end
         else if (i_disp_valid)
         begin
            sub_r <= sub_nxt;
            o_sub_gray <= sub_nxt ^ (sub_nxt >> 1);
         end
      end
   end

   // [R16] store at pointer
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ram_we <= 1'b0;
         o_ram_addr <= `DD_PTR_RST;
         o_ram_data <= 8'h00;
      end
      else
      begin
         o_ram_we <= i_disp_valid && (sub_r == i_sub_pins);
         o_ram_addr <= ptr_r;
         o_ram_data <= i_disp_data;
      end
   end

   blocked_advance_a: assert property ( // [R21]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_disp_valid && !i_ptr_load && (sub_r != i_sub_pins) && !wrap
      |=> !o_ram_we && (ptr_r == $past(ptr_nxt)))
      else $error("blocked display byte stored or pointer not advanced");

   step_size_a: assert property ( // [R22]
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_disp_valid && !i_ptr_load && !wrap && (i_mode == dd_pkg::DD_MUX3)
      |=> ptr_r == 8'($past(ptr_r) + `DD_STEP_MUX3))
      else $error("pointer step wrong in three-way multiplex");
endmodule // dd_ptr

// ---- core/dd_sync.sv ----
module dd_sync #(
   parameter int WIDTH = 2,
   parameter int FILT = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   localparam logic [3:0] FILT_LAST = 4'(FILT - 1);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic meta_r;
         logic stab_r;
         logic out_r;
         logic [3:0] cnt_r;

         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               meta_r <= RST_VAL[g];
               stab_r <= RST_VAL[g];
            end
            else
            begin
               meta_r <= i_async[g];
               stab_r <= meta_r;
            end
         end

         // [R23] spike filter
         // a new level must hold for FILT samples before it is passed on
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               cnt_r <= 4'h0;
               out_r <= RST_VAL[g];
            end
            else if (stab_r == out_r)
               cnt_r <= 4'h0;
            else if (cnt_r == FILT_LAST)
            begin
               out_r <= stab_r;
               cnt_r <= 4'h0;
            end
            else
               cnt_r <= cnt_r + 4'h1;
         end

         assign o_sync[g] = out_r;
      end
   endgenerate
endmodule // dd_sync

// ---- shared/dd_pkg.sv ----
package dd_pkg;
   typedef enum logic [4:0] {
      DD_IDLE = 5'h01,
      DD_ADDR = 5'h02,
      DD_CTRL = 5'h04,
      DD_PAY = 5'h08,
      DD_SKIP = 5'h10
   } dd_state_t;

   typedef enum logic [1:0] {
      DD_STATIC = 2'h0,
      DD_MUX2 = 2'h1,
      DD_MUX3 = 2'h2,
      DD_MUX4 = 2'h3
   } dd_mode_t;

   typedef struct packed {
      logic is_display;
      logic [7:0] data;
   } dd_byte_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } dd_bus_t;
endpackage

// ---- shared/dd_regs.svh ----
`ifndef DD_REGS_SVH
`define DD_REGS_SVH
// ****************************************
// address byte fields
// ****************************************
`define DD_ADDR_PREFIX 6'h1C
`define DD_ADDR_PREFIX_MSB 7
`define DD_ADDR_PREFIX_LSB 2
`define DD_ADDR_STRAP_BIT 1
`define DD_ADDR_RW_BIT 0
// ****************************************
// control byte fields and bit counting
// ****************************************
`define DD_CTRL_MORE_BIT 7
`define DD_CTRL_SEL_BIT 6
`define DD_BIT_FIRST 4'h0
`define DD_BIT_LAST 4'h7
`define DD_BIT_ACK 4'h8
// ****************************************
// data pointer and subaddress counter
// ****************************************
`define DD_STEP_STATIC 8'h08
`define DD_STEP_MUX2 8'h04
`define DD_STEP_MUX3 8'h03
`define DD_STEP_MUX4 8'h02
`define DD_RAM_DEPTH 8'hA0
`define DD_PTR_RST 8'h00
`define DD_SUB_RST 2'h0
// ****************************************
// timing
// ****************************************
`define DD_SPIKE_NS 50
`define DD_LINK_PERIOD_NS 48
`define DD_BUS_IDLE 2'h3
`endif

// ---- verification/dd_i2c_master.sv ----
// ****
// bus master model
// ****
module dd_i2c_master #(
   parameter int Q = 800
) (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // start from idle or as restart
   task automatic start();
      #(Q/2) o_sda = 1'b1;
      #(Q/2) o_scl = 1'b1;
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b0;
   endtask
   task automatic stop();
      #(Q/2) o_sda = 1'b0;
      #(Q/2) o_scl = 1'b1;
      #Q o_sda = 1'b1;
      #Q;
   endtask
   // data moves with clock low, half a phase clear of the edge
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         #(Q/2) o_sda = b[i];
         #(Q/2) o_scl = 1'b1;
         #Q o_scl = 1'b0;
      end
      #(Q/2) o_sda = 1'b1;
      #(Q/2) o_scl = 1'b1;
      // ack pin tied to the data line, so it is sampled
      #(Q/2) ack = i_sda;
      #(Q/2) o_scl = 1'b0;
   endtask
endmodule // dd_i2c_master

// ---- verification/display_driver_i2c_write_slave_tb.sv ----
module display_driver_i2c_write_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b0;
   logic sub_lo = 1'b0;
   logic sub_hi = 1'b0;
   logic ptr_ld = 1'b0;
   logic sub_ld = 1'b0;
   logic [7:0] ptr_val = 8'h00;
   logic [1:0] sub_val = 2'h0;
   dd_pkg::dd_mode_t mode = dd_pkg::DD_STATIC;
   logic scl, m_sda, oe, cmd_v, we, busy;
   logic [7:0] cmd_b, r_addr, r_data, ptr, d;
   logic [7:0] st [4] = '{8'h08, 8'h04, 8'h03, 8'h02};
   logic [7:0] bad [3] = '{8'h70, 8'h73, 8'h76};
   logic [16:0] exp_q [$];
   int error_cnt = 0;
   int compares = 0;
   // open drain: pull-up, low while master or ack drives low
   wire logic sda = m_sda & ~oe;

   initial forever #12.5 clk = ~clk;
   // link clock, phase unrelated to the system clock
   initial
   begin
      #7;
      forever #24 lclk = ~lclk;
   end

   dd_i2c_master m (.i_sda(sda), .o_scl(scl), .o_sda(m_sda));

   dd_i2c_slave dut (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
      .i_ack_out_pin(sda), .o_ack_out_pin(), .o_ack_out_pin_oe(oe),
      .i_addr_bit_strap(strap), .i_subaddr_pin_lo(sub_lo), .i_subaddr_pin_hi(sub_hi),
      .i_drive_mode(mode), .i_ptr_load(ptr_ld), .i_ptr_value(ptr_val),
      .i_sub_load(sub_ld), .i_sub_value(sub_val), .o_cmd_valid(cmd_v),
      .o_cmd_byte(cmd_b), .o_ram_we(we), .o_ram_addr(r_addr), .o_ram_data(r_data),
      .o_busy(busy)
   );

   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic e);
      logic a;
      m.put(b, a);
      chk("ack", {16'h0000, e}, {16'h0000, a});
   endtask

   // loads only with the bus idle
   task automatic load(input logic [7:0] p);
      @(negedge clk);
      ptr_val = p;
      ptr_ld = 1'b1;
      sub_ld = 1'b1;
      @(negedge clk);
      ptr_ld = 1'b0;
      sub_ld = 1'b0;
      ptr = p;
   endtask

   task automatic report_and_stop();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****
   // output watcher
   // ****
   // looked at mid-cycle, where the registered pulses have settled
   always @(negedge clk)
   begin
      if (cmd_v === 1'b1 || we === 1'b1)
      begin
         chk("payload", (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1FFFF,
             cmd_v ? {1'b0, 8'h00, cmd_b} : {1'b1, r_addr, r_data});
      end
   end

   initial
   begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end

   // ****
   // scenarios
   // ****
   initial
   begin
      void'($urandom(32'hFE50EEA0));
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      for (int s = 0; s < 2; s++)
      begin
         @(negedge clk) strap = s[0];
         m.start();
         send({6'h1C, s[0], 1'b0}, 1'b0);
         send(8'h00, 1'b0);
         for (int j = 0; j < 3; j++)
         begin
            d = 8'($urandom);
            exp_q.push_back({1'b0, 8'h00, d});
            send(d, 1'b0);
         end
         m.stop();
      end
      // strap is high here: wrong strap, read, wrong prefix
      foreach (bad[i])
      begin
         m.start();
         send(bad[i], 1'b1);
         send(8'h00, 1'b1);
         chk("busy", 17'h00000, {16'h0000, busy});
         send(8'($urandom), 1'b1);
         m.stop();
      end
      @(negedge clk) strap = 1'b0;
      // end of RAM reached on the second byte: counter moves off the pins
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk) mode = dd_pkg::dd_mode_t'(k[1:0]);
         // pins move per pass, counter loaded to match
         {sub_hi, sub_lo} = 2'(k);
         sub_val = 2'(k);
         load(8'hA0 - (st[k] << 1));
         m.start();
         send(8'h70, 1'b0);
         send(8'h40, 1'b0);
         for (int j = 0; j < 3; j++)
         begin
            d = 8'($urandom);
            if (j < 2)
            begin
               exp_q.push_back({1'b1, ptr, d});
            end
            ptr = ptr + st[k];
            send(d, j == 2);
         end
         m.stop();
      end
      load(8'h10);
      m.start();
      send(8'h70, 1'b0);
      send(8'h80, 1'b0);
      d = 8'($urandom);
      exp_q.push_back({1'b0, 8'h00, d});
      send(d, 1'b0);
      send(8'hC0, 1'b0);
      d = 8'($urandom);
      exp_q.push_back({1'b1, ptr, d});
      send(d, 1'b0);
      send(8'h40, 1'b0);
      chk("busy", 17'h00001, {16'h0000, busy});
      // restart mid access: parsing begins again at the address
      m.start();
      send(8'h70, 1'b0);
      send(8'h40, 1'b0);
      d = 8'($urandom);
      exp_q.push_back({1'b1, ptr + 8'h02, d});
      send(d, 1'b0);
      m.stop();
      repeat (200) @(negedge clk);
      chk("busy", 17'h00000, {16'h0000, busy});
      chk("queue", 17'h00000, 17'(exp_q.size()));
      report_and_stop();
   end
endmodule // display_driver_i2c_write_slave_tb
